// [core/nvb_pkg.sv]
package nvb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          NVB_ADDR_W = 14;
  localparam int          NVB_DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [11:0] NVB_IDX_IRQ_EN   = 12'hFA0;
  localparam logic [11:0] NVB_IDX_IRQ_FLAG = 12'hFA1;
  localparam logic [11:0] NVB_IDX_IRQ_PRIO = 12'hFA2;
  localparam logic [11:0] NVB_IDX_CONTROL  = 12'hFA6;
  localparam logic [11:0] NVB_IDX_UNLOCK   = 12'hFA7;
  localparam logic [11:0] NVB_IDX_DATA     = 12'hFA8;
  localparam logic [11:0] NVB_IDX_ADDRESS  = 12'hFA9;
  localparam logic [11:0] NVB_IDX_CORE_IRQ = 12'hFF2;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int          NVB_CTL_PGM  = 7;
  localparam int          NVB_CTL_CFG  = 6;
  localparam int          NVB_CTL_FREE = 4;
  localparam int          NVB_CTL_ERR  = 3;
  localparam int          NVB_CTL_WRITE_ENABLE_BIT = 2;
  localparam int          NVB_CTL_WR   = 1;
  localparam int          NVB_CTL_RD   = 0;

  // Write-done bit in the interrupt enable, flag and priority registers
  localparam int          NVB_IRQ_DONE_BIT = 4;
  localparam int          NVB_IRQ_W        = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  NVB_ADDR_RST     = 8'h00;
  localparam logic [7:0]  NVB_DATA_RST     = 8'h00;
  localparam logic [7:0]  NVB_CORE_IRQ_RST = 8'h00;
  localparam logic [4:0]  NVB_IRQ_EN_RST   = 5'h00;
  localparam logic [4:0]  NVB_IRQ_FLAG_RST = 5'h00;
  localparam logic [4:0]  NVB_IRQ_PRIO_RST = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key
  localparam logic [7:0]  NVB_KEY_FIRST  = 8'h55;
  localparam logic [7:0]  NVB_KEY_SECOND = 8'hAA;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int          NVB_CLK_HZ        = 50_000_000;
  localparam int          NVB_PWRT_MS       = 72;
  localparam int          NVB_PWRT_CYCLES   = NVB_PWRT_MS * (NVB_CLK_HZ / 1000);
  localparam int          NVB_WRITE_CYCLES  = 200;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    NVB_KEY_IDLE,
    NVB_KEY_GOT_FIRST,
    NVB_KEY_ARMED
  } nvb_key_t;

  typedef struct packed {
    logic pgm;
    logic cfg;
    logic free;
    logic err;
    logic write_enable_bit;
  } nvb_ctrl_t;

endpackage

// [core/nvb_ctrl.sv]
`timescale 1ns/1ps
// Contract
// R1: Byte address register selects one array byte; zero after every reset.
// R2: Byte data register holds read results and write data; zero after every reset.
// R3: Unlock location has no storage; writes only feed the key detector.
// R4: Control bits: pgm 7, cfg 6, none 5, erase 4, error 3, enable 2, start 1, read 0.
// R5: Power-on clears control; other resets keep selects and error, clear the rest.
// R6: Unimplemented bits read zero and ignore writes.
// R7: Write starts only after key 55h then AAh then write-start, in order.
// R8: Write-start reads one during the write and clears itself when done.
// R9: Both select bits clear means reads and writes target the data array.
// R10: Write-done flag is bit 4 of the flag register, zero on reset.
// R11: Write-done enable is bit 4 of the enable register, zero on reset.
// R12: Write-done priority is bit 4 of the priority register, one on reset.
// R13: Write-start refused unless write enable was set by an earlier write.
// R14: Read-start loads the addressed byte at once; it stays until replaced.
// R15: Write completion sets the write-done flag; it stays until software clears it.
// R16: Write enable clear on power-up; writes blocked while power-up timer runs.
// R17: Write length is a parameter; address, data, control frozen while writing.
module nvb_ctrl #(
  parameter int PWRT_CYCLES  = nvb_pkg::NVB_PWRT_CYCLES,
  parameter int WRITE_CYCLES = nvb_pkg::NVB_WRITE_CYCLES
) (
  // Clock and resets
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          other_reset,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [nvb_pkg::NVB_ADDR_W-1:0] paddr,
  input  wire logic [nvb_pkg::NVB_DATA_W-1:0] pwdata,
  output logic      [nvb_pkg::NVB_DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Neighbouring peripheral events, one-cycle pulses
  input  wire logic [3:0]                    periph_event,
  // Status and interrupts
  output logic                               write_busy,
  output logic                               irq,
  output logic                               irq_high_prio
);
  import nvb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [11:0]      idx;
  logic             aligned;
  logic             mapped;
  logic             acc_wr;
  logic [7:0]       wbyte;

  assign idx     = paddr[NVB_ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wbyte   = pwdata[7:0];

  always_comb begin
    unique case (idx)
      NVB_IDX_IRQ_EN, NVB_IDX_IRQ_FLAG, NVB_IDX_IRQ_PRIO, NVB_IDX_CONTROL,
      NVB_IDX_UNLOCK, NVB_IDX_DATA, NVB_IDX_ADDRESS, NVB_IDX_CORE_IRQ: begin
        mapped = aligned;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  assign acc_wr = psel && penable && pwrite && mapped;
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]       addr_reg;
  logic [7:0]       data_reg;
  nvb_ctrl_t        ctrl_reg;
  logic             wr_bit_reg;
  nvb_key_t         key_reg;
  logic [4:0]       irq_en_reg;
  logic [4:0]       irq_flag_reg;
  logic [4:0]       irq_flag_next;
  logic [4:0]       irq_prio_reg;
  logic [7:0]       core_irq_reg;
  logic [21:0]      pwrt_cnt_reg;
  logic             pwrt_done_reg;
  logic [15:0]      wcnt_reg;
  logic [7:0]       mem [256];
  logic [7:0]       rd_byte;

  logic             wr_addr;
  logic             wr_data;
  logic             wr_ctl;
  logic             wr_key;
  logic             sel_data;
  logic             start;
  logic             done;
  logic             rd_start;

  assign wr_addr  = acc_wr && (idx == NVB_IDX_ADDRESS);
  assign wr_data  = acc_wr && (idx == NVB_IDX_DATA);
  assign wr_ctl   = acc_wr && (idx == NVB_IDX_CONTROL);
  assign wr_key   = acc_wr && (idx == NVB_IDX_UNLOCK); // R3
  assign rd_byte  = mem[addr_reg];
  // Selects come from the same write, so one write may point and start
  assign sel_data = !pwdata[NVB_CTL_PGM] && !pwdata[NVB_CTL_CFG]; // R9

  assign start    = wr_ctl && !wr_bit_reg && !other_reset && pwdata[NVB_CTL_WR]
                    && ctrl_reg.write_enable_bit // R13
                    && (key_reg == NVB_KEY_ARMED) // R7
                    && pwrt_done_reg // R16
                    && sel_data; // R9
  assign done     = wr_bit_reg && !other_reset
                    && (wcnt_reg == 16'(WRITE_CYCLES - 1)); // R17
  assign rd_start = wr_ctl && !wr_bit_reg && !other_reset
                    && pwdata[NVB_CTL_RD] && sel_data; // R14

  ////////////////////////////////////////////////////////////////////////////
  // Power-up timer, restarted only by power-on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwrt_cnt_reg  <= '0;
      pwrt_done_reg <= 1'b0;
    end else if (!pwrt_done_reg) begin
      pwrt_cnt_reg  <= pwrt_cnt_reg + 22'h1;
      pwrt_done_reg <= (pwrt_cnt_reg == 22'(PWRT_CYCLES - 1)); // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key detector; any other write to a mapped register breaks the sequence
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      key_reg <= NVB_KEY_IDLE;
    end else if (other_reset) begin
      key_reg <= NVB_KEY_IDLE;
    end else if (wr_key) begin
      if (wbyte == NVB_KEY_FIRST) begin
        key_reg <= NVB_KEY_GOT_FIRST;
      end else if (wbyte == NVB_KEY_SECOND && key_reg == NVB_KEY_GOT_FIRST) begin
        key_reg <= NVB_KEY_ARMED; // R7
      end else begin
        key_reg <= NVB_KEY_IDLE;
      end
    end else if (acc_wr) begin
      key_reg <= NVB_KEY_IDLE; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and data registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= NVB_ADDR_RST;
    end else if (other_reset) begin
      addr_reg <= NVB_ADDR_RST; // R1
    end else if (wr_addr && !wr_bit_reg) begin
      addr_reg <= wbyte; // R17
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_reg <= NVB_DATA_RST;
    end else if (other_reset) begin
      data_reg <= NVB_DATA_RST; // R2
    end else if (rd_start) begin
      data_reg <= rd_byte; // R14
    end else if (wr_data && !wr_bit_reg) begin
      data_reg <= wbyte; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= '0; // R5 R16
    end else if (other_reset) begin
      ctrl_reg.free <= 1'b0; // R5
      ctrl_reg.write_enable_bit <= 1'b0;
      // A write cut short by reset leaves a possibly corrupt byte
      if (wr_bit_reg) begin
        ctrl_reg.err <= 1'b1;
      end
    end else if (wr_ctl && !wr_bit_reg) begin
      ctrl_reg.pgm  <= pwdata[NVB_CTL_PGM]; // R4
      ctrl_reg.cfg  <= pwdata[NVB_CTL_CFG];
      ctrl_reg.free <= pwdata[NVB_CTL_FREE];
      ctrl_reg.err  <= pwdata[NVB_CTL_ERR];
      ctrl_reg.write_enable_bit <= pwdata[NVB_CTL_WRITE_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle timer and array storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_bit_reg <= 1'b0;
      wcnt_reg   <= '0;
    end else if (other_reset || done) begin
      wr_bit_reg <= 1'b0; // R8
      wcnt_reg   <= '0;
    end else if (start) begin
      wr_bit_reg <= 1'b1; // R8
      wcnt_reg   <= '0;
    end else if (wr_bit_reg) begin
      wcnt_reg   <= wcnt_reg + 16'h1; // R17
    end
  end

  // Array is nonvolatile, so it is never reset
  always_ff @(posedge clk) begin
    if (done) begin
      mem[addr_reg] <= data_reg;
    end
  end

  assign write_busy = wr_bit_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flag, enable, priority; flag bits are write-one-to-clear
  always_comb begin
    irq_flag_next = irq_flag_reg;
    if (acc_wr && idx == NVB_IDX_IRQ_FLAG) begin
      irq_flag_next = irq_flag_next & ~pwdata[NVB_IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    irq_flag_next[3:0] = irq_flag_next[3:0] | periph_event;
    if (done) begin
      irq_flag_next[NVB_IRQ_DONE_BIT] = 1'b1; // R15
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_flag_reg <= NVB_IRQ_FLAG_RST;
    end else if (other_reset) begin
      irq_flag_reg <= NVB_IRQ_FLAG_RST; // R10
    end else begin
      irq_flag_reg <= irq_flag_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_reg   <= NVB_IRQ_EN_RST;
      irq_prio_reg <= NVB_IRQ_PRIO_RST;
      core_irq_reg <= NVB_CORE_IRQ_RST;
    end else if (other_reset) begin
      irq_en_reg   <= NVB_IRQ_EN_RST; // R11
      irq_prio_reg <= NVB_IRQ_PRIO_RST; // R12
      core_irq_reg <= NVB_CORE_IRQ_RST;
    end else if (acc_wr) begin
      if (idx == NVB_IDX_IRQ_EN) begin
        irq_en_reg <= pwdata[NVB_IRQ_W-1:0]; // R11
      end
      if (idx == NVB_IDX_IRQ_PRIO) begin
        irq_prio_reg <= pwdata[NVB_IRQ_W-1:0]; // R12
      end
      if (idx == NVB_IDX_CORE_IRQ) begin
        core_irq_reg <= wbyte;
      end
    end
  end

  assign irq           = |(irq_flag_reg & irq_en_reg);
  assign irq_high_prio = |(irq_flag_reg & irq_en_reg & irq_prio_reg); // R12

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase so it is a flop in the access phase
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      NVB_IDX_IRQ_EN:   rd_mux = {3'h0, irq_en_reg}; // R6 R11
      NVB_IDX_IRQ_FLAG: rd_mux = {3'h0, irq_flag_reg}; // R10
      NVB_IDX_IRQ_PRIO: rd_mux = {3'h0, irq_prio_reg}; // R12
      NVB_IDX_CONTROL:  rd_mux = {ctrl_reg.pgm, ctrl_reg.cfg, 1'b0, ctrl_reg.free,
                                  ctrl_reg.err, ctrl_reg.write_enable_bit, wr_bit_reg, 1'b0}; // R4 R8
      NVB_IDX_UNLOCK:   rd_mux = 8'h00; // R3
      NVB_IDX_DATA:     rd_mux = data_reg;
      NVB_IDX_ADDRESS:  rd_mux = addr_reg;
      NVB_IDX_CORE_IRQ: rd_mux = core_irq_reg;
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= (mapped && !pwrite) ? {24'h0, rd_mux} : '0; // R6
      pslverr <= !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Delay bounds must be elaboration constants, not variables
  localparam int WLEN = WRITE_CYCLES;

  sequence s_write_begin;
    $rose(wr_bit_reg);
  endsequence

  sequence s_write_end;
    $fell(wr_bit_reg) && !$past(other_reset);
  endsequence

  a_start_needs_key: assert property ( // R7
    s_write_begin |-> $past(key_reg) == NVB_KEY_ARMED && $past(ctrl_reg.write_enable_bit))
    else $error("write began without unlock key or prior enable");

  a_write_enable_bit_prior: assert property ( // R13
    wr_ctl && pwdata[NVB_CTL_WR] && !ctrl_reg.write_enable_bit && !wr_bit_reg |=> !wr_bit_reg)
    else $error("write began with enable set in the same write");

  a_write_length: assert property ( // R8
    s_write_end |-> $past(wcnt_reg) == 16'(WRITE_CYCLES - 1))
    else $error("write cycle length wrong");

  a_busy_bounded: assert property ( // R17
    s_write_begin |-> ##[1:WLEN] !wr_bit_reg)
    else $error("write cycle did not end in time");

  a_done_flag: assert property ( // R15
    s_write_end |-> irq_flag_reg[NVB_IRQ_DONE_BIT])
    else $error("write-done flag not set at completion");

  a_flag_sticky: assert property ( // R15
    irq_flag_reg[NVB_IRQ_DONE_BIT] && !other_reset
    && !(acc_wr && idx == NVB_IDX_IRQ_FLAG && pwdata[NVB_IRQ_DONE_BIT])
    |=> irq_flag_reg[NVB_IRQ_DONE_BIT])
    else $error("write-done flag dropped without a clear");

  a_read_load: assert property ( // R14
    rd_start |=> data_reg == $past(rd_byte))
    else $error("read did not load the addressed byte");

  a_pwrt_block: assert property ( // R16
    !pwrt_done_reg |=> !$rose(wr_bit_reg))
    else $error("write began during power-up timer");

  a_busy_freeze: assert property ( // R17
    wr_bit_reg && !other_reset |=> $stable(addr_reg) && $stable(data_reg))
    else $error("address or data changed during write");

  a_other_keep: assert property ( // R5
    other_reset |=> ctrl_reg.pgm == $past(ctrl_reg.pgm)
                    && ctrl_reg.cfg == $past(ctrl_reg.cfg) && !ctrl_reg.write_enable_bit)
    else $error("other reset handled control bits wrongly");

  a_regs_cleared: assert property ( // R1
    other_reset |=> addr_reg == NVB_ADDR_RST && data_reg == NVB_DATA_RST)
    else $error("address or data not cleared by reset");

  a_unimpl_zero: assert property ( // R6
    psel && penable && !pwrite && idx == NVB_IDX_CONTROL |-> prdata[5] == 1'b0
      && prdata[31:8] == 24'h0)
    else $error("unimplemented control bits read nonzero");

  a_select_data: assert property ( // R9
    s_write_begin |-> !ctrl_reg.pgm && !ctrl_reg.cfg)
    else $error("write began with a non-data target selected");

endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  import nvb_pkg::*;

  localparam int PW = 20;
  // Long enough that both blocked writes and the status read land inside the cycle
  localparam int WC = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Signals
  logic                  clk;
  logic                  resetn;
  logic                  other_reset;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [NVB_ADDR_W-1:0] paddr;
  logic [NVB_DATA_W-1:0] pwdata;
  logic [NVB_DATA_W-1:0] prdata;
  logic                  pready;
  logic                  pslverr;
  logic [3:0]            periph_event;
  logic                  write_busy;
  logic                  irq;
  logic                  irq_high_prio;
  logic [31:0]           rd;
  logic                  err;
  int                    mismatches;
  int                    n_compared;
  int                    cycles;
  int                    n;
  time                   t_go;
  time                   t_start;
  logic [11:0]           rst_idx [7];
  logic [31:0]           rst_val [7];

  // Short timer and write length keep the run brief
  nvb_ctrl #(
    .PWRT_CYCLES  (PW),
    .WRITE_CYCLES (WC)
  ) DUT (
    .clk           (clk),
    .resetn        (resetn),
    .other_reset   (other_reset),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .periph_event  (periph_event),
    .write_busy    (write_busy),
    .irq           (irq),
    .irq_high_prio (irq_high_prio)
  );

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic final_report;
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles >= 3000) begin
      mismatches++;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // The wait ends when pready is seen high; otherwise the hang guard ends the run
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    t_go    = $time;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Key steps, optional stray write between them, then the start write
  task automatic attempt(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] ctl,
                         input logic mid, input logic exp);
    wr(NVB_IDX_UNLOCK, {24'h0, k1});
    if (mid)
      wr(NVB_IDX_DATA, 32'h0000_003C);
    wr(NVB_IDX_UNLOCK, {24'h0, k2});
    wr(NVB_IDX_CONTROL, {24'h0, ctl});
    t_start = t_go;
    @(posedge clk);
    #1;
    check({31'h0, write_busy}, {31'h0, exp});
  endtask

  task automatic pulse_other_reset;
    @(posedge clk);
    other_reset <= 1'b1;
    @(posedge clk);
    other_reset <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0; resetn = 1'b0; other_reset = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0; periph_event = 4'h0;
    mismatches = 0; n_compared = 0; cycles = 0;
    rst_idx = '{NVB_IDX_IRQ_EN, NVB_IDX_IRQ_FLAG, NVB_IDX_IRQ_PRIO, NVB_IDX_UNLOCK,
                NVB_IDX_DATA, NVB_IDX_ADDRESS, NVB_IDX_CORE_IRQ};
    rst_val = '{32'h00, 32'h00, 32'h1F, 32'h00, 32'h00, 32'h00, 32'h00};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    // Correct sequence while the power-up timer still runs
    wr(NVB_IDX_CONTROL, 32'h0000_0004);
    attempt(8'h55, 8'hAA, 8'h06, 1'b0, 1'b0);
    rchk(NVB_IDX_CONTROL, 32'h0000_0004);
    for (int i = 0; i < 7; i++)
      rchk(rst_idx[i], rst_val[i]);
    apb(1'b0, 12'hFA3, 32'h0000_00FF);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    wr(NVB_IDX_IRQ_EN, 32'hFFFF_FFFF);
    rchk(NVB_IDX_IRQ_EN, 32'h0000_001F);
    wr(NVB_IDX_ADDRESS, 32'hFFFF_FFFF);
    rchk(NVB_IDX_ADDRESS, 32'h0000_00FF);
    wr(NVB_IDX_CONTROL, 32'h0000_0020);
    rchk(NVB_IDX_CONTROL, 32'h0000_0000);
    wr(NVB_IDX_ADDRESS, 32'h0000_0005);
    wr(NVB_IDX_DATA, 32'h0000_003C);
    wr(NVB_IDX_IRQ_EN, 32'h0000_0010);
    // Refused starts: enable set in same write, wrong order, stray write, program select
    attempt(8'h55, 8'hAA, 8'h06, 1'b0, 1'b0);
    attempt(8'hAA, 8'h55, 8'h06, 1'b0, 1'b0);
    attempt(8'h55, 8'hAA, 8'h06, 1'b1, 1'b0);
    attempt(8'h55, 8'hAA, 8'h86, 1'b0, 1'b0);
    wr(NVB_IDX_CONTROL, 32'h0000_0004);
    attempt(8'h55, 8'hAA, 8'h06, 1'b0, 1'b1);
    // Writes during the cycle must not land
    wr(NVB_IDX_ADDRESS, 32'h0000_0077);
    wr(NVB_IDX_DATA, 32'h0000_0011);
    rchk(NVB_IDX_CONTROL, 32'h0000_0006);
    n = 0;
    while (write_busy === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(($time - 1 - t_start) / 20), WC);
    rchk(NVB_IDX_ADDRESS, 32'h0000_0005);
    rchk(NVB_IDX_DATA, 32'h0000_003C);
    rchk(NVB_IDX_IRQ_FLAG, 32'h0000_0010);
    check({31'h0, irq}, 32'h1);
    check({31'h0, irq_high_prio}, 32'h1);
    // A neighbour event, then a one-to-clear of the write-done flag only
    periph_event <= 4'h1;
    @(posedge clk);
    periph_event <= 4'h0;
    wr(NVB_IDX_IRQ_FLAG, 32'h0000_0010);
    rchk(NVB_IDX_IRQ_FLAG, 32'h0000_0001);
    check({31'h0, irq}, 32'h0);
    // Read the written byte back from the array
    wr(NVB_IDX_DATA, 32'h0000_0000);
    wr(NVB_IDX_CONTROL, 32'h0000_0005);
    rchk(NVB_IDX_DATA, 32'h0000_003C);
    // Other reset keeps selects and error, clears the rest
    wr(NVB_IDX_CONTROL, 32'h0000_008C);
    pulse_other_reset;
    rchk(NVB_IDX_CONTROL, 32'h0000_0088);
    rchk(NVB_IDX_ADDRESS, 32'h0000_0000);
    rchk(NVB_IDX_DATA, 32'h0000_0000);
    rchk(NVB_IDX_IRQ_PRIO, 32'h0000_001F);
    rchk(NVB_IDX_IRQ_FLAG, 32'h0000_0000);
    rchk(NVB_IDX_IRQ_EN, 32'h0000_0000);
    final_report;
  end
endmodule
